// ### hdl/qusp_fifo.sv
/*
 qusp_fifo: synchronous fifo with valid and ready on both sides.
 assumes one clock and a synchronous active low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module qusp_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] DEPTH = (AW+1)'(D);

   logic [W-1:0] mem [D];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0]   cnt_q;
   logic [AW:0]   cnt_d;
   logic          push;
   logic          pop;

   ////////////////////////////////////////////////////////////////////////
   // handshakes and occupancy
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rp_q];
   assign out_valid = (cnt_q != '0);
   assign in_ready  = (cnt_q != DEPTH);

   always_comb begin
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   // pointers and count
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
      end
   end

   // storage
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wp_q] <= in_data;
      end
   end

   a_fifo_bound: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (cnt_q == DEPTH) |=> (cnt_q == DEPTH) || $past(pop))
      else $error("fifo count grew past its depth");
endmodule
`default_nettype wire

// ### hdl/qusp_pkg.sv
/*
 qusp_pkg: shared constants for the quad serial pin and status block.
 assumes a single 10 MHz reference clock and four identical channels.
*/
package qusp_pkg;
   // channel count and data widths
   localparam int NCH          = 4;
   localparam int CHW          = 2;
   localparam int DW           = 8;

   // status byte layout
   localparam int STAT_TX_LSB  = 0;
   localparam int STAT_RX_LSB  = 4;

   // tx stream fifo: channel number above the data byte
   localparam int FIFO_W       = DW + CHW;
   localparam int FIFO_D       = 16;

   // bit timing: sixteen ticks per bit
   localparam int CLK_HZ       = 10_000_000;
   localparam int BAUD_HZ      = 125_000;
   localparam int OVS          = 16;
   localparam int TICK_DIV     = CLK_HZ / (BAUD_HZ * OVS);
   localparam logic [2:0] TICK_LAST = 3'(TICK_DIV - 1);
   localparam logic [3:0] TICK_MAX  = 4'(OVS - 1);
   localparam logic [3:0] MID_TICK  = 4'(OVS / 2 - 1);

   // frame: start, eight data, stop
   localparam logic [3:0] LAST_BIT  = 4'h9;
   localparam logic [3:0] STOP_BIT  = 4'h9;

   // infrared pulse is three of sixteen ticks
   localparam logic [3:0] IR_TICKS  = 4'h3;
   localparam logic [4:0] IR_HOLD   = 5'h10;

   // reset values of pins
   localparam logic TX_STD_IDLE = 1'b1;
   localparam logic TX_IR_IDLE  = 1'b0;
endpackage

// ### hdl/qusp_top.sv
/*
 qusp_top: four channel serial pins, modem pins and the direct-select
 fifo ready status byte.
 assumes control inputs come from logic on ref_clk; pins are asynchronous.
*/
`timescale 1ns/100ps
`default_nettype none
module qusp_top
   import qusp_pkg::*;
(
   input  wire logic                      ref_clk,
   input  wire logic                      rst_b,
   input  wire logic                      fifo_status_select_n,
   output logic [qusp_pkg::DW-1:0]        data_out,
   output logic                           data_oe,
   input  wire logic [qusp_pkg::DW-1:0]   tx_data,
   input  wire logic [qusp_pkg::CHW-1:0]  tx_chan,
   input  wire logic                      tx_valid,
   output logic                           tx_ready,
   input  wire logic [qusp_pkg::NCH-1:0]  rx_take,
   output logic [qusp_pkg::NCH*8-1:0]     rx_hold,
   input  wire logic [qusp_pkg::NCH-1:0]  ir_mode_sel,
   input  wire logic [qusp_pkg::NCH-1:0]  rts_ctrl,
   input  wire logic [qusp_pkg::NCH-1:0]  dtr_ctrl,
   input  wire logic [qusp_pkg::NCH-1:0]  auto_rts_en,
   input  wire logic [qusp_pkg::NCH-1:0]  auto_cts_en,
   input  wire logic [qusp_pkg::NCH-1:0]  rx_pin,
   output logic [qusp_pkg::NCH-1:0]       tx_pin,
   output logic [qusp_pkg::NCH-1:0]       infrared_tx_out,
   output logic [qusp_pkg::NCH-1:0]       rts_n,
   input  wire logic [qusp_pkg::NCH-1:0]  cts_n,
   output logic [qusp_pkg::NCH-1:0]       dtr_n,
   input  wire logic [qusp_pkg::NCH-1:0]  dsr_n,
   input  wire logic [qusp_pkg::NCH-1:0]  cd_n,
   output logic [qusp_pkg::NCH-1:0]       cts_stat,
   output logic [qusp_pkg::NCH-1:0]       dsr_stat,
   output logic [qusp_pkg::NCH-1:0]       cd_stat,
   output logic [qusp_pkg::NCH-1:0]       tx_ready_n,
   output logic [qusp_pkg::NCH-1:0]       rx_ready_n
);
   import qusp_pkg::*;

   localparam int SW = 4 * NCH + 1;

   logic [SW-1:0]          sync1_q, sync2_q;
   logic [NCH-1:0]         rx_s, cts_s, dsr_s, cd_s;
   logic                   sel_s, tick_q, f_valid, f_ready;
   logic [2:0]             div_q;
   logic [FIFO_W-1:0]      f_data;
   logic [CHW-1:0]         f_chan;
   logic [NCH-1:0]         thr_full_q, tx_start, tx_busy_q, tx_lvl, ir_pulse;
   logic [NCH-1:0]         rx_line, rx_busy_q, rx_full_q;
   logic [NCH-1:0][DW-1:0] thr_q, rsh_q, rhr_q;
   logic [NCH-1:0][9:0]    tsh_q;
   logic [NCH-1:0][3:0]    tcnt_q, tbit_q, rcnt_q, rbit_q;
   logic [NCH-1:0][4:0]    irh_q;

   ////////////////////////////////////////////////////////////////////////
   // two stage synchronisers for every pin input
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         sync1_q <= '1;
         sync2_q <= '1;
      end else begin
         sync1_q <= {fifo_status_select_n, cd_n, dsr_n, cts_n, rx_pin};
         sync2_q <= sync1_q;
      end
   end

   assign rx_s  = sync2_q[NCH-1:0];
   assign cts_s = sync2_q[2*NCH-1:NCH];
   assign dsr_s = sync2_q[3*NCH-1:2*NCH];
   assign cd_s  = sync2_q[4*NCH-1:3*NCH];
   assign sel_s = sync2_q[4*NCH];

   ////////////////////////////////////////////////////////////////////////
   // status byte onto the bus; no address involved
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         data_out <= '0;
         data_oe  <= 1'b0;
      end else begin
         data_oe <= !sel_s;
         if (!sel_s) begin
            data_out[STAT_TX_LSB +: NCH] <= ~tx_ready_n;
            data_out[STAT_RX_LSB +: NCH] <= rx_ready_n;
         end
      end
   end

   a_status_byte_map: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !sel_s |=> (data_out == {$past(rx_ready_n), ~$past(tx_ready_n)}))
      else $error("status byte does not match ready outputs");
   a_bus_drive: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!sel_s ##1 !sel_s) |=> data_oe && $past(data_oe))
      else $error("bus not driven while select is low");
   a_bus_release: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(sel_s) |=> !data_oe)
      else $error("bus still driven after select went high");

   ////////////////////////////////////////////////////////////////////////
   // sixteen-times bit tick
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (div_q == TICK_LAST);
         div_q  <= (div_q == TICK_LAST) ? 3'h0 : div_q + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmit stream buffer, then per channel holding register
   qusp_fifo #(.W(FIFO_W), .D(FIFO_D)) u_tx_fifo (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .in_data   ({tx_chan, tx_data}),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (f_ready)
   );

   assign f_chan  = f_data[FIFO_W-1:DW];
   // a busy holding register stalls the whole stream
   assign f_ready = f_valid && !thr_full_q[f_chan];

   // start a frame unless clear-to-send holds it off
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         tx_start[i] = !tx_busy_q[i] && thr_full_q[i] && !(auto_cts_en[i] && cts_s[i]);
         tx_lvl[i]   = tx_busy_q[i] ? tsh_q[i][0] : TX_STD_IDLE;
         ir_pulse[i] = tx_busy_q[i] && !tsh_q[i][0] && (tcnt_q[i] < IR_TICKS);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         thr_full_q <= '0;
         thr_q      <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (f_ready && (f_chan == CHW'(i))) begin
               thr_full_q[i] <= 1'b1;
               thr_q[i]      <= f_data[DW-1:0];
            end else if (tx_start[i]) begin
               thr_full_q[i] <= 1'b0;
            end
         end
      end
   end

   // transmit shifters
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         tx_busy_q <= '0;
         tsh_q     <= '0;
         tcnt_q    <= '0;
         tbit_q    <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (tx_start[i]) begin
               tx_busy_q[i] <= 1'b1;
               tsh_q[i]     <= {1'b1, thr_q[i], 1'b0};
               tcnt_q[i]    <= '0;
               tbit_q[i]    <= '0;
            end else if (tx_busy_q[i] && tick_q) begin
               tcnt_q[i] <= tcnt_q[i] + 4'h1;
               if (tcnt_q[i] == TICK_MAX) begin
                  tsh_q[i]  <= {1'b1, tsh_q[i][9:1]};
                  tbit_q[i] <= tbit_q[i] + 4'h1;
                  if (tbit_q[i] == LAST_BIT) begin
                     tx_busy_q[i] <= 1'b0;
                  end
               end
            end
         end
      end
   end

   // output pins: tx_pin plain or encoded per channel, infrared_tx_out always encoded
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         tx_pin          <= {NCH{TX_STD_IDLE}};
         infrared_tx_out <= {NCH{TX_IR_IDLE}};
      end else begin
         for (int i = 0; i < NCH; i++) begin
            tx_pin[i] <= ir_mode_sel[i] ? ir_pulse[i] : tx_lvl[i];
         end
         infrared_tx_out <= ir_pulse;
      end
   end

   a_tx_reset_high: assert property (@(posedge ref_clk)
      !rst_b |=> (tx_pin == {NCH{TX_STD_IDLE}}))
      else $error("tx pin not high after reset cycle");
   a_std_idle_high: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ((~tx_pin) & ~$past(ir_mode_sel) & ~$past(tx_busy_q)) == '0)
      else $error("plain tx pin low while idle");
   a_ir_idle_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (tx_pin & $past(ir_mode_sel) & ~$past(tx_busy_q)) == '0)
      else $error("infrared tx pin high while idle");
   a_infrared_tx_out_idle_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (infrared_tx_out & ~$past(tx_busy_q)) == '0)
      else $error("infrared output high while idle");
   a_cts_hold_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ((auto_cts_en & cts_s & ~tx_busy_q) != '0) |=> ((tx_busy_q & ~$past(tx_busy_q) & $past(auto_cts_en & cts_s)) == '0))
      else $error("frame started while clear-to-send was off");

   ////////////////////////////////////////////////////////////////////////
   // infrared receive pulses stretched back into plain levels
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         irh_q <= '0;
      end else if (tick_q) begin
         for (int i = 0; i < NCH; i++) begin
            if (!ir_mode_sel[i]) begin
               irh_q[i] <= '0;                    // plain idle high is no pulse train
            end else if (rx_s[i]) begin
               irh_q[i] <= IR_HOLD;
            end else if (irh_q[i] != '0) begin
               irh_q[i] <= irh_q[i] - 5'h01;
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         rx_line[i] = ir_mode_sel[i] ? (irh_q[i] == '0) : rx_s[i];
      end
   end

   // receive shifters; a good stop bit loads the holding register
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rx_busy_q <= '0;
         rcnt_q    <= '0;
         rbit_q    <= '0;
         rsh_q     <= '0;
         rhr_q     <= '0;
         rx_full_q <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (rx_take[i]) begin
               rx_full_q[i] <= 1'b0;
            end
            if (tick_q) begin
               if (!rx_busy_q[i]) begin
                  if (!rx_line[i]) begin
                     rx_busy_q[i] <= 1'b1;
                     rcnt_q[i]    <= '0;
                     rbit_q[i]    <= '0;
                  end
               end else begin
                  rcnt_q[i] <= rcnt_q[i] + 4'h1;
                  if (rcnt_q[i] == MID_TICK) begin
                     rbit_q[i] <= rbit_q[i] + 4'h1;
                     if (rbit_q[i] == 4'h0 && rx_line[i]) begin
                        rx_busy_q[i] <= 1'b0;
                     end else if (rbit_q[i] == STOP_BIT) begin
                        rx_busy_q[i] <= 1'b0;
                        if (rx_line[i]) begin
                           rhr_q[i]     <= rsh_q[i];
                           rx_full_q[i] <= 1'b1;           // set beats take
                        end
                     end else if (rbit_q[i] != 4'h0) begin
                        rsh_q[i] <= {rx_line[i], rsh_q[i][DW-1:1]};
                     end
                  end
               end
            end
         end
      end
   end

   assign rx_hold = rhr_q;

   ////////////////////////////////////////////////////////////////////////
   // ready outputs, modem outputs and status inputs
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         tx_ready_n <= '0;
         rx_ready_n <= '1;
         rts_n      <= '1;
         dtr_n      <= '1;
         cts_stat   <= '0;
         dsr_stat   <= '0;
         cd_stat    <= '0;
      end else begin
         tx_ready_n <= thr_full_q;
         rx_ready_n <= ~rx_full_q;
         for (int i = 0; i < NCH; i++) begin
            // automatic mode drops the request while a byte is unread
            rts_n[i] <= auto_rts_en[i] ? (!rts_ctrl[i] || rx_full_q[i]) : !rts_ctrl[i];
         end
         dtr_n    <= ~dtr_ctrl;
         cts_stat <= ~cts_s;
         dsr_stat <= ~dsr_s;
         cd_stat  <= ~cd_s;
      end
   end

   a_tx_ready_n_track: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (tx_ready_n == $past(thr_full_q)) && (rx_ready_n == ~$past(rx_full_q)))
      else $error("ready outputs do not follow holding state");
   a_rts_manual: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ((rts_n ^ ~$past(rts_ctrl)) & ~$past(auto_rts_en)) == '0)
      else $error("request-to-send does not follow software");
   a_dtr_follow: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $changed(dtr_ctrl) |=> (dtr_n == ~$past(dtr_ctrl)))
      else $error("terminal-ready does not follow software");
   a_modem_status: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (dsr_stat == ~$past(dsr_s)) && (cd_stat == ~$past(cd_s)))
      else $error("modem status inputs misreported");
endmodule
`default_nettype wire

// ### test/quad_uart_serial_pin_status_tb_top.sv
/*
 quad_uart_serial_pin_status_tb_top: self-checking bench for qusp_top.
 assumes qusp_remote on the serial side and 80 clocks a bit.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
$display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module quad_uart_serial_pin_status_tb_top;
   import qusp_pkg::*;
   logic             ref_clk = 1'b0;
   logic             rst_b, fifo_status_select_n, tx_valid, data_oe, tx_ready;
   logic [DW-1:0]    tx_data, data_out, b;
   logic [CHW-1:0]   tx_chan;
   logic [NCH*8-1:0] rx_hold;
   logic [NCH-1:0]   rx_take, ir_mode_sel, rts_ctrl, dtr_ctrl, auto_rts_en, auto_cts_en;
   logic [NCH-1:0]   rx_pin, tx_pin, infrared_tx_out, rts_n, cts_n, dtr_n, dsr_n, cd_n;
   logic [NCH-1:0]   cts_stat, dsr_stat, cd_stat, tx_ready_n, rx_ready_n;
   logic [31:0]      seed = 32'h0000_3B51, r;
   logic [7:0]       vals [0:39];
   logic [9:0]       fa, fb;
   int               miscompares, total_checks, n;

   // 10 MHz reference clock
   always #50 ref_clk = ~ref_clk;

   qusp_top dut (.ref_clk, .rst_b, .fifo_status_select_n, .data_out, .data_oe, .tx_data, .tx_chan,
      .tx_valid, .tx_ready, .rx_take, .rx_hold, .ir_mode_sel, .rts_ctrl, .dtr_ctrl, .auto_rts_en,
      .auto_cts_en, .rx_pin, .tx_pin, .infrared_tx_out, .rts_n, .cts_n, .dtr_n, .dsr_n, .cd_n,
      .cts_stat, .dsr_stat, .cd_stat, .tx_ready_n, .rx_ready_n);

   qusp_remote remote (.ref_clk, .tx_line(tx_pin), .ir_line(infrared_tx_out), .rx_line(rx_pin),
      .cts_line_n(cts_n));

   ////////////////////////////////////////////////////////////////////////////
   // xorshift source and expected status byte
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [7:0] exp_status(input logic [3:0] held, input logic [3:0] pend);
      return {~pend, ~held};
   endfunction

   task automatic close_out();
      if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // select pin read with exact latency, then release
   task automatic status_read(input logic [7:0] exp);
      @(posedge ref_clk);
      fifo_status_select_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK(data_oe, 1'b0);
      @(negedge ref_clk);
      `CHK(data_oe, 1'b1);
      `CHK(data_out, exp);
      @(posedge ref_clk);
      fifo_status_select_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK(data_oe, 1'b0);
   endtask

   // offer one byte until the edge that takes it
   task automatic push(input logic [1:0] ch, input logic [7:0] v);
      int k = 0;
      @(posedge ref_clk);
      tx_data  <= v;
      tx_chan  <= ch;
      tx_valid <= 1'b1;
      do begin
         @(posedge ref_clk);
         k++;
      end while (tx_ready !== 1'b1 && k < 30000);
      tx_valid <= 1'b0;
   endtask

   task automatic wait_rx(input int c);
      int k = 0;
      while (rx_ready_n[c] !== 1'b0 && k < 3000) begin
         @(posedge ref_clk);
         k++;
      end
      @(negedge ref_clk);
   endtask

   task automatic take(input int c);
      @(posedge ref_clk);
      rx_take[c] <= 1'b1;
      @(posedge ref_clk);
      rx_take[c] <= 1'b0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK(rx_ready_n, 4'hF);
      `CHK(rts_n[c], 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // watchdog
   initial begin
      repeat (60000) @(posedge ref_clk);
      miscompares++;
      close_out();
   end

   // main sequence
   initial begin
      rst_b = 1'b0; fifo_status_select_n = 1'b1; tx_data = 8'h00; tx_chan = 2'h0; tx_valid = 1'b0;
      rx_take = 4'h0; ir_mode_sel = 4'h0; rts_ctrl = 4'h0; dtr_ctrl = 4'h0; auto_rts_en = 4'h0;
      auto_cts_en = 4'h0; dsr_n = 4'hF; cd_n = 4'hF; miscompares = 0; total_checks = 0;
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK(tx_pin, 4'hF);
      `CHK(infrared_tx_out, 4'h0);
      `CHK({tx_ready_n, rx_ready_n}, 8'h0F);
      `CHK({rts_n, dtr_n, data_oe}, 9'h1FF ^ 9'h001);
      @(posedge ref_clk);
      rst_b <= 1'b1;
      status_read(exp_status(4'h0, 4'h0));
      // modem pins from random control and inputs
      for (int i = 0; i < 4; i++) begin
         r = xs();
         @(posedge ref_clk);
         {cd_n, dsr_n, dtr_ctrl, rts_ctrl} <= r[15:0];
         remote.cts_line_n <= r[19:16];
         repeat (4) @(posedge ref_clk);
         @(negedge ref_clk);
         `CHK(rts_n, ~r[3:0]);
         `CHK(dtr_n, ~r[7:4]);
         `CHK({cd_stat, dsr_stat}, ~r[15:8]);
         `CHK(cts_stat, ~r[19:16]);
      end
      remote.cts_line_n <= 4'h0;
      // plain frames, dedicated infrared copy alongside
      for (int c = 0; c < 4; c++) begin
         r = xs();
         b = (c == 0) ? 8'h00 : (c == 1) ? 8'hFF : r[7:0];
         fork
            push(2'(c), b);
            remote.capture(2'(c), 1'b0, 1'b0, fa);
            remote.capture(2'(c), 1'b0, 1'b1, fb);
         join
         `CHK(fa, {1'b1, b, 1'b0});
         `CHK(fb, {1'b1, b, 1'b0});
         repeat (100) @(posedge ref_clk);
         @(negedge ref_clk);
         `CHK({tx_pin, infrared_tx_out}, 8'hF0);
      end
      // infrared mode on channels 0 and 1, their receive lines parked at infrared idle
      @(posedge ref_clk);
      remote.rx_line[1:0] <= 2'b00;
      repeat (3) @(posedge ref_clk);
      ir_mode_sel <= 4'h3;
      r = xs();
      fork
         push(2'd1, r[7:0]);
         remote.capture(2'd1, 1'b1, 1'b0, fa);
      join
      `CHK(fa, {1'b1, r[7:0], 1'b0});
      repeat (100) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK(tx_pin, 4'hC);
      ir_mode_sel <= 4'h0;
      remote.rx_line[1:0] <= 2'b11;
      repeat (100) @(posedge ref_clk);
      // receive with automatic request-to-send, host asserts it first
      rts_ctrl <= 4'hF;
      auto_rts_en <= 4'hF;
      for (int c = 0; c < 4; c++) begin
         r = xs();
         {cd_n, dsr_n} <= r[15:8];
         remote.send(2'(c), 1'b0, r[7:0]);
         wait_rx(c);
         `CHK(rx_hold[c*8 +: 8], r[7:0]);
         `CHK(rts_n[c], 1'b1);
         status_read(exp_status(4'h0, 4'(1 << c)));
         take(c);
      end
      // infrared receive on channel 2, line parked low first
      remote.rx_line[2] <= 1'b0;
      repeat (3) @(posedge ref_clk);
      ir_mode_sel <= 4'h4;
      repeat (100) @(posedge ref_clk);
      r = xs();
      remote.send(2'd2, 1'b1, r[7:0]);
      wait_rx(2);
      `CHK(rx_hold[23:16], r[7:0]);
      take(2);
      ir_mode_sel <= 4'h0;
      repeat (2) @(posedge ref_clk);
      remote.rx_line[2] <= 1'b1;
      // far side stalls: fill buffer on channel 3 until refused
      auto_cts_en <= 4'hF;
      remote.cts_line_n <= 4'hF;
      n = 0;
      repeat (4) @(negedge ref_clk);
      while (tx_ready === 1'b1 && n < 40) begin
         r = xs();
         vals[n] = r[7:0];
         push(2'd3, r[7:0]);
         n++;
         repeat (4) @(negedge ref_clk);
      end
      `CHK(n, FIFO_D + 1);
      `CHK(tx_pin, 4'hF);
      status_read(exp_status(4'h8, 4'h0));
      // release and drain in order
      remote.cts_line_n <= 4'h0;
      for (int i = 0; i < n; i++) begin
         remote.capture(2'd3, 1'b0, 1'b0, fa);
         `CHK(fa, {1'b1, vals[i], 1'b0});
      end
      repeat (100) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK({tx_ready, tx_ready_n}, 5'h10);
      close_out();
   end
endmodule
`default_nettype wire

// ### test/qusp_remote.sv
/*
 qusp_remote: far-side serial transceiver model for the four channels.
 assumes 80 reference clocks per bit and registered transmit pins.
*/
`timescale 1ns/100ps
`default_nettype none
module qusp_remote (
   input  wire logic [0:0] ref_clk,
   input  wire logic [3:0] tx_line,
   input  wire logic [3:0] ir_line,
   output logic [3:0]      rx_line,
   output logic [3:0]      cts_line_n
);
   // lines idle high, peer ready to take data
   initial begin
      rx_line    = 4'hF;
      cts_line_n = 4'h0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one 8N1 frame, zeros as short high pulses in infrared mode
   task automatic send(input logic [1:0] ch, input logic ir, input logic [7:0] b);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         for (int k = 0; k < 80; k++) begin
            @(posedge ref_clk);
            rx_line[ch] <= ir ? (~fr[i] & (k < 15)) : fr[i];
         end
      end
      @(posedge ref_clk);
      rx_line[ch] <= ~ir;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // capture one frame; ded watches the dedicated infrared output
   task automatic capture(input logic [1:0] ch, input logic ir, input logic ded, output logic [9:0] fr);
      int   n;
      logic enc;
      enc = ir | ded;
      n = 0;
      while ((ded ? ir_line[ch] : tx_line[ch]) !== enc && n < 30000) begin
         @(posedge ref_clk);
         n++;
      end
      for (int i = 0; i < 10; i++) begin
         repeat (i == 0 ? (enc ? 7 : 40) : 80) @(posedge ref_clk);
         fr[i] = enc ^ (ded ? ir_line[ch] : tx_line[ch]);
      end
   endtask
endmodule
`default_nettype wire
